// ==== rtl/lct_loop_counter.sv ====
/*
  lct_loop_counter: one level of a nested loop, driven by control tokens.
  holds the count, the loop test sequencer, the markers and the apb
  register view.
  assumes: tokens and parameters come from logic on pclk, so nothing is
  synchronised; tokens are one-cycle pulses and only one circulates.
*/
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - loop test is le, lt, gt or ge
// - loop begin token loads the start value
// - iteration finished token adds the step
// - compare new count with limit after either
// - pass gives iteration go token, valid high
// - fail gives loop finished token, valid low
// - active from loop begin to finished token
// - each loop begin samples fresh start, limit
// - count output meaningful only while valid
// - enable low: valid low, state frozen
// - enable high again resumes where frozen
// - first and final pass markers per loop
// - empty range marker when first test fails
// - nonzero latency, overhead cycle at end
// - next activation may start some cycles later
module lct_loop_counter #(
  parameter int unsigned W = 16  // count, start, step and limit width
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // suspend control
  input  wire logic         enable,
  // incoming tokens
  input  wire logic         loop_begin_token,
  input  wire logic         iteration_finished_token,
  // loop parameters
  input  wire logic [W-1:0] start_value,
  input  wire logic [W-1:0] step_value,
  input  wire logic [W-1:0] limit_value,
  // outgoing tokens
  output logic              iteration_go_token,
  output logic              loop_finished_token,
  // loop view
  output logic              valid,
  output logic [W-1:0]      count,
  output logic              loop_active,
  output logic              first_pass_marker,
  output logic              final_pass_marker,
  output logic              empty_range_marker
);

  // sequencer state
  lct_pkg::lct_state_e state;       // current state
  lct_pkg::lct_state_e next_state;  // state after this edge

  // parameters caught at loop begin
  logic [W-1:0]        step_q;   // step for this activation
  logic [W-1:0]        limit_q;  // limit for this activation
  lct_pkg::lct_test_e  mode_q;   // loop test for this activation
  lct_pkg::lct_test_e  cfg_mode; // loop test as software last wrote it

  // iteration bookkeeping
  logic                first_q;     // no iteration finished yet
  logic [31:0]         iter;        // go tokens since loop begin
  logic [W-1:0]        next_count;  // count plus step, wraps at W bits
  logic                pass_now;    // loop test on the current count
  logic                pass_next;   // loop test one step ahead

  // event strobes, all qualified by enable
  logic                take_begin;  // loop begin accepted
  logic                take_done;   // iteration finished accepted
  logic                eval_pass;   // test passed in eval
  logic                eval_fail;   // test failed in eval

  // status word for software
  logic [lct_pkg::LCT_STAT_W-1:0] stat;

  // step adder; a wrap past W bits is the user's range problem
  assign next_count = count + step_q;

  // loop test on the freshly loaded or stepped count
  lct_compare #(
    .W    (W)
  ) u_test_now (
    .mode (mode_q),
    .lhs  (count),
    .rhs  (limit_q),
    .pass (pass_now)
  );

  // same test one step ahead, tells whether this pass is the last
  lct_compare #(
    .W    (W)
  ) u_test_next (
    .mode (mode_q),
    .lhs  (next_count),
    .rhs  (limit_q),
    .pass (pass_next)
  );

  // tokens outside their state are dropped; a frozen block drops all.
  // a begin token that lands in the gap cycle is lost as well, so an
  // outer level must not fire the next activation in the same cycle as the
  // finished token; the gap is the delay that the partner is warned of
  assign take_begin = enable && (state == lct_pkg::LCT_ST_IDLE) && loop_begin_token;
  assign take_done  = enable && (state == lct_pkg::LCT_ST_BODY) &&
                      iteration_finished_token;
  assign eval_pass  = enable && (state == lct_pkg::LCT_ST_EVAL) && pass_now;
  assign eval_fail  = enable && (state == lct_pkg::LCT_ST_EVAL) && !pass_now;

  // next state; with enable low everything holds
  always_comb begin
    next_state = state;
    if (enable) begin
      unique case (state)
        lct_pkg::LCT_ST_IDLE: begin
          // one cycle from token to test gives nonzero latency
          if (loop_begin_token) begin
            next_state = lct_pkg::LCT_ST_EVAL;
          end
        end
        lct_pkg::LCT_ST_EVAL: begin
          if (pass_now) begin
            next_state = lct_pkg::LCT_ST_BODY;
          end else begin
            next_state = lct_pkg::LCT_ST_GAP;
          end
        end
        lct_pkg::LCT_ST_BODY: begin
          if (iteration_finished_token) begin
            next_state = lct_pkg::LCT_ST_EVAL;
          end
        end
        lct_pkg::LCT_ST_GAP: begin
          // overhead cycle lets an outer level settle its tokens
          next_state = lct_pkg::LCT_ST_IDLE;
        end
      endcase
    end
  end

  // only reset acts without pclk; every other change waits for an edge
  // state register; frozen while disabled, so resume is exact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= lct_pkg::LCT_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // counter: load on loop begin, step on iteration finished
  // the count is kept after loop end, so software can still read the
  // value that failed the test; a zero step never ends the loop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (take_begin) begin
      count <= start_value;
    end else if (take_done) begin
      count <= next_count;
    end
  end

  // catch the parameters each activation, so triangular loops work;
  // catching them also shields the loop from late input changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q  <= '0;
      limit_q <= '0;
      mode_q  <= lct_pkg::LCT_CFG_RST;
    end else if (take_begin) begin
      step_q  <= step_value;
      limit_q <= limit_value;
      mode_q  <= cfg_mode;
    end
  end

  // first flag: set by loop begin, cleared by the first finished body
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q <= 1'b0;
    end else if (take_begin) begin
      first_q <= 1'b1;
    end else if (take_done) begin
      first_q <= 1'b0;
    end
  end

  // outgoing tokens: one-cycle pulses from the eval state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iteration_go_token  <= 1'b0;
      loop_finished_token <= 1'b0;
    end else begin
      iteration_go_token  <= eval_pass;
      loop_finished_token <= eval_fail;
    end
  end

  // valid follows the body state and drops while disabled
  // taken from next_state so valid rises with the go token and falls on
  // the edge that takes the iteration finished token rather than one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid <= 1'b0;
    end else begin
      valid <= enable && (next_state == lct_pkg::LCT_ST_BODY);
    end
  end

  // active from loop begin; already low in the cycle of the finished token
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_active <= 1'b0;
    end else begin
      loop_active <= (next_state == lct_pkg::LCT_ST_EVAL) ||
                     (next_state == lct_pkg::LCT_ST_BODY);
    end
  end

  // first and final markers stand for the whole body state
  // they are not masked by enable: a suspended body still knows
  // whether it runs the first or the last pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_pass_marker <= 1'b0;
      final_pass_marker <= 1'b0;
    end else if (next_state == lct_pkg::LCT_ST_BODY) begin
      first_pass_marker <= first_q;
      final_pass_marker <= !pass_next;
    end else begin
      first_pass_marker <= 1'b0;
      final_pass_marker <= 1'b0;
    end
  end

  // empty marker: a loop that fails its very first test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_range_marker <= 1'b0;
    end else if (eval_fail) begin
      empty_range_marker <= first_q;
    end else if (state != lct_pkg::LCT_ST_GAP) begin
      empty_range_marker <= 1'b0;
    end
  end

  // iteration count for software, cleared on each loop begin
  // kept after loop end, so the pass count can be read once it is over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iter <= lct_pkg::LCT_ITER_RST;
    end else if (take_begin) begin
      iter <= lct_pkg::LCT_ITER_RST;
    end else if (eval_pass) begin
      iter <= iter + 32'h0000_0001;
    end
  end

  // status word; every bit is a flop or the enable level
  // enable is shown raw, so software sees a suspend as it happens
  always_comb begin
    stat                           = '0;
    stat[lct_pkg::LCT_STAT_ACTIVE] = loop_active;
    stat[lct_pkg::LCT_STAT_VALID]  = valid;
    stat[lct_pkg::LCT_STAT_FIRST]  = first_pass_marker;
    stat[lct_pkg::LCT_STAT_FINAL]  = final_pass_marker;
    stat[lct_pkg::LCT_STAT_EMPTY]  = empty_range_marker;
    stat[lct_pkg::LCT_STAT_ENABLE] = enable;
  end

  // register view over apb
  lct_apb #(
    .W        (W)
  ) u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .cfg_mode (cfg_mode),
    .stat     (stat),
    .count    (count),
    .iter     (iter)
  );

endmodule

`default_nettype wire

// ==== common/lct_pkg.sv ====
/*
  lct_pkg: shared constants and types for the loop counter token block.
  assumes: a 32-bit apb bus, and register offsets that are byte addresses.
*/
package lct_pkg;

  // apb register byte offsets
  localparam logic [7:0] LCT_OFF_CFG   = 8'h00;  // loop test setting, read/write
  localparam logic [7:0] LCT_OFF_STAT  = 8'h04;  // live status, read only
  localparam logic [7:0] LCT_OFF_COUNT = 8'h08;  // current count, read only
  localparam logic [7:0] LCT_OFF_ITER  = 8'h0c;  // go tokens since loop begin, read only

  // status register bit positions
  localparam int unsigned LCT_STAT_ACTIVE = 0;
  localparam int unsigned LCT_STAT_VALID  = 1;
  localparam int unsigned LCT_STAT_FIRST  = 2;
  localparam int unsigned LCT_STAT_FINAL  = 3;
  localparam int unsigned LCT_STAT_EMPTY  = 4;
  localparam int unsigned LCT_STAT_ENABLE = 5;
  localparam int unsigned LCT_STAT_W      = 6;

  // loop test encodings, held in cfg bits 1:0
  typedef enum logic [1:0] {
    LCT_TEST_LE = 2'b00,  // count <= limit
    LCT_TEST_LT = 2'b01,  // count <  limit
    LCT_TEST_GT = 2'b10,  // count >  limit
    LCT_TEST_GE = 2'b11   // count >= limit
  } lct_test_e;

  // values after reset
  localparam lct_test_e   LCT_CFG_RST   = LCT_TEST_LE;
  localparam logic [31:0] LCT_RDATA_RST = 32'h0000_0000;
  localparam logic [31:0] LCT_ITER_RST  = 32'h0000_0000;

  // control sequencer states
  typedef enum logic [1:0] {
    LCT_ST_IDLE = 2'b00,  // inactive, waiting for a loop begin token
    LCT_ST_EVAL = 2'b01,  // compare the fresh count with the limit
    LCT_ST_BODY = 2'b10,  // body running, waiting for iteration finished
    LCT_ST_GAP  = 2'b11   // overhead cycle after loop end
  } lct_state_e;

endpackage

// ==== rtl/lct_compare.sv ====
/*
  lct_compare: the static loop test between a count and a limit.
  assumes: both operands are unsigned and of the same width.
*/
`timescale 1ns/1ps
`default_nettype none

module lct_compare #(
  parameter int unsigned W = 16
) (
  // test setting
  input  wire lct_pkg::lct_test_e mode,
  // operands
  input  wire logic [W-1:0]       lhs,
  input  wire logic [W-1:0]       rhs,
  // result
  output logic                    pass
);

  // pure combinational test, no state
  always_comb begin
    pass = 1'b0;  // safe value should the setting ever be unknown
    unique case (mode)
      lct_pkg::LCT_TEST_LE: pass = (lhs <= rhs);
      lct_pkg::LCT_TEST_LT: pass = (lhs <  rhs);
      lct_pkg::LCT_TEST_GT: pass = (lhs >  rhs);
      lct_pkg::LCT_TEST_GE: pass = (lhs >= rhs);
    endcase
  end

endmodule

`default_nettype wire

// ==== rtl/lct_apb.sv ====
/*
  lct_apb: apb slave with the cfg register and the read mux.
  assumes: pclk domain only; one wait state per transfer.
*/
`timescale 1ns/1ps
`default_nettype none

module lct_apb #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // block side
  output lct_pkg::lct_test_e                 cfg_mode,
  input  wire logic [lct_pkg::LCT_STAT_W-1:0] stat,
  input  wire logic [W-1:0]                  count,
  input  wire logic [31:0]                   iter
);

  logic [31:0] rd_word;  // read mux result
  logic        rd_miss;  // address maps to nothing

  // decode; unmapped reads give zero and an error
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_miss = 1'b0;
    unique case (paddr)
      lct_pkg::LCT_OFF_CFG:   rd_word = {30'h0000_0000, cfg_mode};
      lct_pkg::LCT_OFF_STAT:  rd_word = {{(32-lct_pkg::LCT_STAT_W){1'b0}}, stat};
      lct_pkg::LCT_OFF_COUNT: rd_word = {{(32-W){1'b0}}, count};
      lct_pkg::LCT_OFF_ITER:  rd_word = iter;
      default:                rd_miss = 1'b1;
    endcase
  end

  // one wait state keeps every bus output on a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= lct_pkg::LCT_RDATA_RST;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? lct_pkg::LCT_RDATA_RST : rd_word;
      pslverr <= rd_miss;
    end else begin
      pready  <= 1'b0;
      prdata  <= lct_pkg::LCT_RDATA_RST;
      pslverr <= 1'b0;
    end
  end

  // cfg write lands on the edge that completes the transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_mode <= lct_pkg::LCT_CFG_RST;
    end else if (psel && penable && pready && pwrite && paddr == lct_pkg::LCT_OFF_CFG) begin
      cfg_mode <= lct_pkg::lct_test_e'(pwdata[1:0]);
    end
  end

endmodule

`default_nettype wire

// ==== test/lct_loop_counter_sva.sv ====
/* checker for the loop counter token block, seeing only its ports.
   assumes: bound into every lct_loop_counter instance; one clock domain. */
`timescale 1ns/1ps
`default_nettype none

module lct_loop_counter_sva #(
  parameter int unsigned W = 16
) (
  // clock, reset and bus answer
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pready,
  // loop side
  input wire logic         enable,
  input wire logic         loop_begin_token,
  input wire logic         iteration_go_token,
  input wire logic         loop_finished_token,
  input wire logic         valid,
  input wire logic [W-1:0] count,
  input wire logic         loop_active,
  input wire logic         first_pass_marker,
  input wire logic         empty_range_marker
);
  // all checks share pclk and the async reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_GO_PULSE: assert property (iteration_go_token |=> !iteration_go_token)
    else $error("go token lasted more than one cycle");
  AST_ONE_TOKEN: assert property (!(iteration_go_token && loop_finished_token))
    else $error("go and finished tokens together");
  AST_GO_VALID: assert property (iteration_go_token |-> valid)
    else $error("go token without valid");
  AST_DONE_LOW: assert property (loop_finished_token |-> !valid && !loop_active)
    else $error("finished token with valid or active high");
  AST_ACTIVE_END: assert property ($fell(loop_active) |-> loop_finished_token)
    else $error("active fell without a finished token");
  AST_START: assert property ((loop_begin_token && enable && !loop_active
    && !loop_finished_token) ##1 enable |-> loop_active
    ##1 (iteration_go_token || loop_finished_token))
    else $error("begin token not answered two edges later");
  AST_FIRST: assert property ($rose(loop_active) ##1 iteration_go_token |-> first_pass_marker)
    else $error("first pass marker missing");
  AST_EMPTY: assert property ($rose(empty_range_marker) && enable |->
    loop_finished_token ##1 empty_range_marker ##1 !empty_range_marker)
    else $error("empty marker not a two cycle pulse at loop end");
  AST_SUSPEND: assert property (!enable |=> !valid && $stable(count))
    else $error("valid or count moved while disabled");
  AST_APB_ANSWER: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not a one cycle pulse");
endmodule

bind lct_loop_counter lct_loop_counter_sva #(.W(W)) u_sva (
  .pclk, .presetn, .psel, .penable, .pready, .enable, .loop_begin_token,
  .iteration_go_token, .loop_finished_token, .valid, .count, .loop_active,
  .first_pass_marker, .empty_range_marker
);

`default_nettype wire

// ==== test/lct_body_model.sv ====
/* loop body model: answers each go token with a finished token.
   assumes: lat is steady per loop; body pauses while enable is low. */
`timescale 1ns/1ps
`default_nettype none

module lct_body_model (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // bench controls
  input wire logic       enable,
  input wire logic [3:0] lat,
  // tokens
  input wire logic       iteration_go_token,
  output logic           iteration_finished_token
);
  logic [3:0] left;  // body cycles still to run

  // body timer; counting stops while suspended so no token is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 4'h0;
      iteration_finished_token <= 1'b0;
    end else begin
      iteration_finished_token <= 1'b0;
      if (iteration_go_token) begin
        left <= lat;
        iteration_finished_token <= (lat == 4'h0);  // prompt answer
      end else if (left != 4'h0 && enable) begin
        left <= left - 4'h1;
        iteration_finished_token <= (left == 4'h1);
      end
    end
  end
endmodule

`default_nettype wire

// ==== test/test_lct_loop_counter.sv ====
/* bench for the loop counter token block: bus checks and loop runs.
   assumes: lct_body_model plays the loop body; checker is bound. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", n, e, s); end end

module test_lct_loop_counter;
  localparam int unsigned W = 16;  // count width
  // driven by the bench
  logic pclk, presetn, psel, penable, pwrite, enable, bgn;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata;
  logic [W-1:0] start, step, limit, k;
  logic [3:0]   lat;  // body latency
  // seen from the design
  logic pready, pslverr, go, fin, done, valid, act, first, final_m, empty;
  logic [W-1:0] count;
  // notes of expected results
  logic [W+5:0] lq[$], el;  // active, valid, done, first, final, empty, count
  logic [32:0]  aq[$], ea;  // pslverr, prdata
  int n_mismatch, checked, cyc;
  lct_pkg::lct_test_e m;

  lct_loop_counter #(.W(W)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .enable(enable),
    .loop_begin_token(bgn), .iteration_finished_token(fin), .start_value(start),
    .step_value(step), .limit_value(limit), .iteration_go_token(go),
    .loop_finished_token(done), .valid(valid), .count(count), .loop_active(act),
    .first_pass_marker(first), .final_pass_marker(final_m), .empty_range_marker(empty));
  lct_body_model u_body (.pclk(pclk), .presetn(presetn), .enable(enable), .lat(lat),
    .iteration_go_token(go), .iteration_finished_token(fin));

  // clock at 20 mhz
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // expected loop test, worked out from the settings
  function automatic logic pass_fn(lct_pkg::lct_test_e t, logic [W-1:0] c, logic [W-1:0] l);
    case (t)
      lct_pkg::LCT_TEST_LE: pass_fn = (c <= l);
      lct_pkg::LCT_TEST_LT: pass_fn = (c < l);
      lct_pkg::LCT_TEST_GT: pass_fn = (c > l);
      default: pass_fn = (c >= l);
    endcase
  endfunction

  // one apb transfer; waits for pready, never a fixed count
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [32:0] e);
    aq.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // one loop activation; sus suspends the block after each go token
  task automatic run(lct_pkg::lct_test_e t, logic [W-1:0] s, logic [W-1:0] st,
                     logic [W-1:0] l, logic [3:0] lt, logic sus);
    logic [W-1:0] c;
    logic         fp;
    logic [31:0]  n;
    apb(1'b1, lct_pkg::LCT_OFF_CFG, {30'h0, t}, 33'h0);
    start <= s;
    step <= st;
    limit <= l;
    lat <= lt;
    c = s;
    fp = 1'b1;
    n = 32'h0;
    while (pass_fn(t, c, l)) begin
      lq.push_back({2'b11, 1'b0, fp, !pass_fn(t, c + st, l), 1'b0, c});
      c = c + st;
      fp = 1'b0;
      n++;
    end
    lq.push_back({3'b001, 2'b00, fp, c});
    bgn <= 1'b1;
    @(posedge pclk);
    bgn <= 1'b0;
    while (done !== 1'b1) begin
      @(posedge pclk);
      if (sus && go === 1'b1) begin
        enable <= 1'b0;
        repeat (3) @(posedge pclk);
        enable <= 1'b1;
      end
    end
    apb(1'b0, lct_pkg::LCT_OFF_ITER, 32'h0, {1'b0, n});
    apb(1'b0, lct_pkg::LCT_OFF_COUNT, 32'h0, {17'h0, c});
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // watcher: each token or bus answer retires the oldest note
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      end_sim();
    end
    if (go === 1'b1 || done === 1'b1) begin
      el = lq.pop_front();
      `CHK("loop", el, {act, valid, done, first, final_m, empty, count})
    end
    if (pready === 1'b1) begin
      ea = aq.pop_front();
      `CHK("apb", ea, {pslverr, prdata})
    end
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, bgn, paddr, pwdata} = '0;
    {start, step, limit, lat} = '0;
    enable = 1'b1;
    void'($urandom(4));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lct_pkg::LCT_OFF_CFG, 32'h0, {1'b0, 32'h0});
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});  // unmapped place
    apb(1'b1, 8'h10, 32'h0000_0003, {1'b1, 32'h0});  // unmapped write refused
    apb(1'b1, lct_pkg::LCT_OFF_STAT, 32'hffff_ffff, 33'h0);
    apb(1'b0, lct_pkg::LCT_OFF_STAT, 32'h0, 33'h1 << lct_pkg::LCT_STAT_ENABLE);
    enable <= 1'b0;
    bgn <= 1'b1;
    @(posedge pclk);
    bgn <= 1'b0;
    @(posedge pclk);
    enable <= 1'b1;
    @(posedge pclk);
    `CHK("active", 1'b0, act)
    run(lct_pkg::LCT_TEST_LE, 16'h0, 16'h1, 16'h1, 4'h0, 1'b0);
    run(lct_pkg::LCT_TEST_LT, 16'h5, 16'h1, 16'h5, 4'h5, 1'b0);
    run(lct_pkg::LCT_TEST_GT, 16'h9, 16'hfffd, 16'h2, 4'h5, 1'b0);
    run(lct_pkg::LCT_TEST_GE, 16'h4, 16'hffff, 16'h4, 4'h2, 1'b1);
    for (int i = 0; i < 24; i++) begin
      m = lct_pkg::lct_test_e'($urandom % 4);
      k = W'(1 + $urandom % 3);
      run(m, W'($urandom % 16), m[1] ? -k : k, W'(3 + $urandom % 13),
          4'(1 + $urandom % 5), 1'($urandom % 2));
    end
    `CHK("notes left", 32'h0, 32'(lq.size() + aq.size()))
    end_sim();
  end
endmodule

`default_nettype wire
